// file: common/csc_map.svh
// Register offsets, field positions, reset values and timing counts of the clock source control.
// Assumes byte addresses on a 32-bit APB bus; register data sits in the low eight bits.
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH

// Register byte offsets
`define CSC_OFF_PROC_CLK_CTRL 8'h00
`define CSC_OFF_MAIN_CLK_MODE 8'h04
`define CSC_OFF_OSC_MODE_SEL 8'h08
`define CSC_OFF_MAIN_OSC_CTRL 8'h0C
`define CSC_OFF_INT_OSC_MODE 8'h10
`define CSC_OFF_STATUS 8'h14

// Processor clock control fields
`define CSC_BIT_DIV_LO 0
`define CSC_BIT_DIV_HI 2
`define CSC_BIT_CPU_SRC_SEL 4
`define CSC_BIT_CPU_ON_SUB 5
`define CSC_BIT_SUB_XTAL_START 6
`define CSC_RST_DIV 3'h1
`define CSC_DIV_MAX 3'h4
`define CSC_DIV_SUB 3'h1

// Main clock mode fields
`define CSC_BIT_MAIN_MODE 0
`define CSC_BIT_MAIN_ON_HS 1
`define CSC_BIT_MAIN_SRC_SEL 2

// Oscillator mode select fields
`define CSC_BIT_FREQ_RANGE 0
`define CSC_BIT_SUB_OSC_SEL 4
`define CSC_BIT_SUB_EXT_IN 5
`define CSC_BIT_MAIN_OSC_SEL 6
`define CSC_BIT_MAIN_EXT_IN 7

// Main oscillator control and internal oscillator mode fields
`define CSC_BIT_MAIN_OSC_STOP 7
`define CSC_RST_MAIN_OSC_STOP 1'h1
`define CSC_BIT_IHS_STOP 0
`define CSC_BIT_LOWSPD_STOP 1
`define CSC_BIT_IHS_RUNNING 7

// Status register fields
`define CSC_BIT_ST_CPU_BUSY 0
`define CSC_BIT_ST_PERI_BUSY 1
`define CSC_BIT_ST_POC_HOLD 2
`define CSC_BIT_ST_LOWSPD_RUN 3

// Timing
`define CSC_CLK_PERIOD_NS 10
`define CSC_POC_RESET_NS 20000
`define CSC_POC_RESET_CYC ((`CSC_POC_RESET_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)
`define CSC_POC_CNT_W 12
`define CSC_SETTLE_LAST 3'h6

`endif

// file: common/csc_pkg.sv
// Types shared by the clock source control and its helper modules.
// Assumes nothing beyond a SystemVerilog compiler.
package csc_pkg;

	// Clock sources that may drive the CPU; the low-speed oscillator has no code here
	typedef enum logic [1:0] {
		CSC_SRC_IHS,
		CSC_SRC_HS,
		CSC_SRC_SUB
	} csc_src_e;

	// Handover sequencer states
	typedef enum logic [1:0] {
		CSC_HOV_IDLE,
		CSC_HOV_OLD,
		CSC_HOV_NEW
	} csc_hov_e;

	// Option byte straps
	typedef struct packed {
		logic wdt_en;
		logic lowspd_nostop;
		logic poc_mode;
	} csc_opt_s;

	// Oscillator and clock input enables
	typedef struct packed {
		logic ihs_run;
		logic main_xtal;
		logic main_ext;
		logic main_freq_range;
		logic sub_xtal;
		logic sub_ext;
		logic lowspd_run;
		logic wdt_clk;
	} csc_osc_en_s;

endpackage

// file: rtl/csc_sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes inputs are quasi-static levels or slow clocks well below the sampling rate.
`timescale 1ns/1ps
module csc_sync3 #(
	parameter int W = 1
) (
	input wire logic clk, // Sampling clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [W-1:0] din, // Asynchronous input
	output logic [W-1:0] dout // Filtered, synchronous output
);
	logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
	logic [W-1:0] out_next;

	// Output follows only when stages two and three agree, so a metastable settle never shows
	always_comb begin
		out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
	end

	// Shift chain; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign dout = out_reg;
endmodule

// file: rtl/csc_clk_handover.sv
// Glitch-free handover sequencer for one clock selector.
// Assumes lvl carries synchronised levels of the candidate clocks, bit index equal to the source code.
`timescale 1ns/1ps
module csc_clk_handover (
	input wire logic clk, // System clock
	input wire logic rst_n, // Asynchronous reset, active low
	input csc_pkg::csc_src_e target, // Requested source
	input wire logic [2:0] lvl, // Synchronised clock levels
	output csc_pkg::csc_src_e cur, // Source currently handed to the load
	output logic gate_on, // Clock gate open
	output logic busy // Handover in progress
);
	csc_pkg::csc_hov_e state_reg, state_next;
	csc_pkg::csc_src_e cur_reg, cur_next, pend_reg, pend_next;

	// Close the gate on a new request, wait for the old clock low, then switch while the new one is low
	always_comb begin
		state_next = state_reg;
		cur_next = cur_reg;
		pend_next = pend_reg;
		unique case (state_reg)
			csc_pkg::CSC_HOV_IDLE: begin
				if (target != cur_reg) begin
					pend_next = target; // [RQ20]
					state_next = csc_pkg::CSC_HOV_OLD;
				end
			end
			csc_pkg::CSC_HOV_OLD: begin
				if (!lvl[cur_reg]) begin
					state_next = csc_pkg::CSC_HOV_NEW; // [RQ20]
				end
			end
			csc_pkg::CSC_HOV_NEW: begin
				if (!lvl[pend_reg]) begin
					cur_next = pend_reg; // [RQ20]
					state_next = csc_pkg::CSC_HOV_IDLE;
				end
			end
		endcase
	end

	// State and selection registers; reset lands on the internal high-speed source
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= csc_pkg::CSC_HOV_IDLE;
			cur_reg <= csc_pkg::CSC_SRC_IHS;
			pend_reg <= csc_pkg::CSC_SRC_IHS;
		end else begin
			state_reg <= state_next;
			cur_reg <= cur_next;
			pend_reg <= pend_next;
		end
	end

	assign cur = cur_reg;
	assign gate_on = (state_reg == csc_pkg::CSC_HOV_IDLE);
	assign busy = (state_reg != csc_pkg::CSC_HOV_IDLE);
endmodule

// file: rtl/csc_top.sv
// Clock source control: APB register file, oscillator enables and CPU/peripheral source selection.
// Assumes APB master on MCLK, oscillator clock levels and option straps arriving asynchronously.
// Operation
// [RQ1] Two status bits report CPU clock source
// [RQ2] Clearing subsystem select stops crystal and input
// [RQ3] Software checks CPU off subsystem before stopping
// [RQ4] STOP state leaves subsystem oscillator running
// [RQ5] Low-speed clock never drives the CPU
// [RQ6] Low-speed oscillator starts after reset, feeds watchdog
// [RQ7] Low-speed stop bit halts and restarts oscillator
// [RQ8] Non-stoppable option makes low-speed stop bit inert
// [RQ9] Main-source and mode bits pick main clocks
// [RQ10] Main mode register field positions
// [RQ11] Oscillator mode select register field positions
// [RQ12] Processor and main oscillator control positions
// [RQ13] Reset lands CPU on internal high-speed clock
// [RQ14] Software sequence for switching to high-speed clock
// [RQ15] Range and main-source bits change once only
// [RQ16] Software sequence for switching to subsystem clock
// [RQ17] Dual-threshold mode holds CPU for 20 us
// [RQ18] Main clock feeds CPU through divider bits
// [RQ19] Subsystem clock feeds CPU divided by two
// [RQ20] Source handover is glitch-free, status follows it
`timescale 1ns/1ps
`include "csc_map.svh"
module csc_top (
	input wire logic MCLK, // System clock, 100 MHz
	input wire logic RST_B, // Asynchronous reset, active low
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB enable
	input wire logic PWRITE, // APB write
	input wire logic [7:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error on unmapped address
	input csc_pkg::csc_opt_s OPT_PINS, // Option byte straps
	input wire logic STOP_MODE, // Standby STOP state from CPU core
	input wire logic [2:0] CLK_LVL, // Raw levels of internal, high-speed and subsystem clocks
	output csc_pkg::csc_src_e CPU_SRC, // Source driving the CPU
	output logic CPU_CLK_GATE, // CPU clock gate open
	output logic [2:0] CPU_DIV_EXP, // CPU divide exponent
	output csc_pkg::csc_src_e PERI_SRC, // Source driving peripherals
	output logic PERI_CLK_GATE, // Peripheral clock gate open
	output csc_pkg::csc_osc_en_s OSC_EN // Oscillator and input enables
);
	localparam logic [`CSC_POC_CNT_W-1:0] POC_LAST = `CSC_POC_CNT_W'(`CSC_POC_RESET_CYC - 1);

	// Control fields
	logic [2:0] div_reg, div_next;
	logic cpu_sel_reg, cpu_sel_next;
	logic xstart_reg, xstart_next;
	logic mmode_reg, mmode_next;
	logic msrc_reg, msrc_next;
	logic msrc_lock_reg, msrc_lock_next;
	logic range_reg, range_next;
	logic range_lock_reg, range_lock_next;
	logic sub_sel_reg, sub_sel_next;
	logic sub_ext_reg, sub_ext_next;
	logic main_sel_reg, main_sel_next;
	logic main_ext_reg, main_ext_next;
	logic main_osc_stop_reg, main_osc_stop_next;
	logic ihs_stop_reg, ihs_stop_next;
	logic ls_stop_reg, ls_stop_next;
	logic [31:0] rdata_reg, rdata_next;

	// Strap capture and power-on hold
	logic [2:0] settle_reg, settle_next;
	logic opt_valid_reg, opt_valid_next;
	csc_pkg::csc_opt_s opt_reg, opt_next;
	logic [`CSC_POC_CNT_W-1:0] poc_cnt_reg, poc_cnt_next;
	logic poc_hold_reg, poc_hold_next;

	// Outputs
	csc_pkg::csc_osc_en_s osc_reg, osc_next;
	logic [2:0] cdiv_reg, cdiv_next;

	// Wires
	logic [2:0] opt_sync;
	logic [2:0] lvl_sync;
	csc_pkg::csc_src_e cpu_target, peri_target, cpu_cur, peri_cur;
	logic cpu_gate, cpu_busy, peri_gate, peri_busy;
	logic wr_en, rd_setup, mapped;
	logic [7:0] wd;
	logic ls_run;

	// Straps and clock levels come from outside MCLK
	csc_sync3 #(.W(3)) u_opt_sync (
		.clk(MCLK),
		.rst_n(RST_B),
		.din(OPT_PINS),
		.dout(opt_sync)
	);

	csc_sync3 #(.W(3)) u_lvl_sync (
		.clk(MCLK),
		.rst_n(RST_B),
		.din(CLK_LVL),
		.dout(lvl_sync)
	);

	// Source requests; low-speed oscillator has no code in the selector type
	always_comb begin
		peri_target = msrc_reg ? csc_pkg::CSC_SRC_HS : csc_pkg::CSC_SRC_IHS; // [RQ9]
		if (cpu_sel_reg) begin
			cpu_target = csc_pkg::CSC_SRC_SUB; // [RQ19]
		end else if (msrc_reg && mmode_reg) begin
			cpu_target = csc_pkg::CSC_SRC_HS; // [RQ9] [RQ18]
		end else begin
			cpu_target = csc_pkg::CSC_SRC_IHS; // [RQ5] [RQ9]
		end
	end

	csc_clk_handover u_cpu_hov (
		.clk(MCLK),
		.rst_n(RST_B),
		.target(cpu_target),
		.lvl(lvl_sync),
		.cur(cpu_cur),
		.gate_on(cpu_gate),
		.busy(cpu_busy)
	);

	csc_clk_handover u_peri_hov (
		.clk(MCLK),
		.rst_n(RST_B),
		.target(peri_target),
		.lvl(lvl_sync),
		.cur(peri_cur),
		.gate_on(peri_gate),
		.busy(peri_busy)
	);

	// Bus decode; every access completes without wait states
	assign wr_en = PSEL && PENABLE && PWRITE && mapped;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign wd = PWDATA[7:0];
	always_comb begin
		case (PADDR)
			`CSC_OFF_PROC_CLK_CTRL, `CSC_OFF_MAIN_CLK_MODE, `CSC_OFF_OSC_MODE_SEL,
			`CSC_OFF_MAIN_OSC_CTRL, `CSC_OFF_INT_OSC_MODE, `CSC_OFF_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Register writes; range and main-source fields lock after their first change
	always_comb begin
		div_next = div_reg;
		cpu_sel_next = cpu_sel_reg;
		xstart_next = xstart_reg;
		mmode_next = mmode_reg;
		msrc_next = msrc_reg;
		msrc_lock_next = msrc_lock_reg;
		range_next = range_reg;
		range_lock_next = range_lock_reg;
		sub_sel_next = sub_sel_reg;
		sub_ext_next = sub_ext_reg;
		main_sel_next = main_sel_reg;
		main_ext_next = main_ext_reg;
		main_osc_stop_next = main_osc_stop_reg;
		ihs_stop_next = ihs_stop_reg;
		ls_stop_next = ls_stop_reg;
		if (wr_en) begin
			case (PADDR)
				`CSC_OFF_PROC_CLK_CTRL: begin
					// Prohibited divider codes are dropped so the CPU never sees an undefined ratio
					if (wd[`CSC_BIT_DIV_HI:`CSC_BIT_DIV_LO] <= `CSC_DIV_MAX) begin
						div_next = wd[`CSC_BIT_DIV_HI:`CSC_BIT_DIV_LO]; // [RQ18]
					end
					cpu_sel_next = wd[`CSC_BIT_CPU_SRC_SEL]; // [RQ12]
					xstart_next = wd[`CSC_BIT_SUB_XTAL_START]; // [RQ12]
				end
				`CSC_OFF_MAIN_CLK_MODE: begin
					mmode_next = wd[`CSC_BIT_MAIN_MODE]; // [RQ10]
					if (!msrc_lock_reg && (wd[`CSC_BIT_MAIN_SRC_SEL] != msrc_reg)) begin
						msrc_next = wd[`CSC_BIT_MAIN_SRC_SEL]; // [RQ10] [RQ15]
						msrc_lock_next = 1'b1; // [RQ15]
					end
				end
				`CSC_OFF_OSC_MODE_SEL: begin
					main_ext_next = wd[`CSC_BIT_MAIN_EXT_IN]; // [RQ11]
					main_sel_next = wd[`CSC_BIT_MAIN_OSC_SEL]; // [RQ11]
					sub_ext_next = wd[`CSC_BIT_SUB_EXT_IN]; // [RQ11]
					sub_sel_next = wd[`CSC_BIT_SUB_OSC_SEL]; // [RQ11]
					if (!range_lock_reg && (wd[`CSC_BIT_FREQ_RANGE] != range_reg)) begin
						range_next = wd[`CSC_BIT_FREQ_RANGE]; // [RQ11] [RQ15]
						range_lock_next = 1'b1; // [RQ15]
					end
				end
				`CSC_OFF_MAIN_OSC_CTRL: begin
					main_osc_stop_next = wd[`CSC_BIT_MAIN_OSC_STOP]; // [RQ12]
				end
				`CSC_OFF_INT_OSC_MODE: begin
					ihs_stop_next = wd[`CSC_BIT_IHS_STOP];
					ls_stop_next = wd[`CSC_BIT_LOWSPD_STOP]; // [RQ7]
				end
				default: begin
				end
			endcase
		end
	end

	// Read data is fetched in the setup cycle and held through the access cycle
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_setup) begin
			rdata_next = 32'h0000_0000;
			case (PADDR)
				`CSC_OFF_PROC_CLK_CTRL: begin
					rdata_next[`CSC_BIT_DIV_HI:`CSC_BIT_DIV_LO] = div_reg;
					rdata_next[`CSC_BIT_CPU_SRC_SEL] = cpu_sel_reg;
					rdata_next[`CSC_BIT_CPU_ON_SUB] = (cpu_cur == csc_pkg::CSC_SRC_SUB); // [RQ1] [RQ20]
					rdata_next[`CSC_BIT_SUB_XTAL_START] = xstart_reg;
				end
				`CSC_OFF_MAIN_CLK_MODE: begin
					rdata_next[`CSC_BIT_MAIN_MODE] = mmode_reg;
					rdata_next[`CSC_BIT_MAIN_ON_HS] = (cpu_cur == csc_pkg::CSC_SRC_HS); // [RQ1] [RQ20]
					rdata_next[`CSC_BIT_MAIN_SRC_SEL] = msrc_reg;
				end
				`CSC_OFF_OSC_MODE_SEL: begin
					rdata_next[`CSC_BIT_MAIN_EXT_IN] = main_ext_reg;
					rdata_next[`CSC_BIT_MAIN_OSC_SEL] = main_sel_reg;
					rdata_next[`CSC_BIT_SUB_EXT_IN] = sub_ext_reg;
					rdata_next[`CSC_BIT_SUB_OSC_SEL] = sub_sel_reg;
					rdata_next[`CSC_BIT_FREQ_RANGE] = range_reg;
				end
				`CSC_OFF_MAIN_OSC_CTRL: begin
					rdata_next[`CSC_BIT_MAIN_OSC_STOP] = main_osc_stop_reg;
				end
				`CSC_OFF_INT_OSC_MODE: begin
					rdata_next[`CSC_BIT_IHS_RUNNING] = osc_reg.ihs_run;
					rdata_next[`CSC_BIT_LOWSPD_STOP] = ls_stop_reg;
					rdata_next[`CSC_BIT_IHS_STOP] = ihs_stop_reg;
				end
				`CSC_OFF_STATUS: begin
					rdata_next[`CSC_BIT_ST_CPU_BUSY] = cpu_busy;
					rdata_next[`CSC_BIT_ST_PERI_BUSY] = peri_busy;
					rdata_next[`CSC_BIT_ST_POC_HOLD] = poc_hold_reg;
					rdata_next[`CSC_BIT_ST_LOWSPD_RUN] = osc_reg.lowspd_run;
				end
				default: begin
				end
			endcase
		end
	end

	// Control registers; reset values give internal high-speed CPU operation untouched
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			div_reg <= `CSC_RST_DIV;
			cpu_sel_reg <= 1'b0; // [RQ13]
			xstart_reg <= 1'b0;
			mmode_reg <= 1'b0; // [RQ13]
			msrc_reg <= 1'b0; // [RQ13]
			msrc_lock_reg <= 1'b0;
			range_reg <= 1'b0;
			range_lock_reg <= 1'b0;
			sub_sel_reg <= 1'b0;
			sub_ext_reg <= 1'b0;
			main_sel_reg <= 1'b0;
			main_ext_reg <= 1'b0;
			main_osc_stop_reg <= `CSC_RST_MAIN_OSC_STOP;
			ihs_stop_reg <= 1'b0;
			ls_stop_reg <= 1'b0; // [RQ6]
			rdata_reg <= 32'h0000_0000;
		end else begin
			div_reg <= div_next;
			cpu_sel_reg <= cpu_sel_next;
			xstart_reg <= xstart_next;
			mmode_reg <= mmode_next;
			msrc_reg <= msrc_next;
			msrc_lock_reg <= msrc_lock_next;
			range_reg <= range_next;
			range_lock_reg <= range_lock_next;
			sub_sel_reg <= sub_sel_next;
			sub_ext_reg <= sub_ext_next;
			main_sel_reg <= main_sel_next;
			main_ext_reg <= main_ext_next;
			main_osc_stop_reg <= main_osc_stop_next;
			ihs_stop_reg <= ihs_stop_next;
			ls_stop_reg <= ls_stop_next;
			rdata_reg <= rdata_next;
		end
	end

	// Straps are caught once the synchroniser has settled, then the dual-threshold hold runs
	// The filter output lags four edges, so an earlier capture would latch the reset zeros
	always_comb begin
		settle_next = settle_reg;
		opt_valid_next = opt_valid_reg;
		opt_next = opt_reg;
		poc_cnt_next = poc_cnt_reg;
		poc_hold_next = poc_hold_reg;
		if (!opt_valid_reg) begin
			if (settle_reg == `CSC_SETTLE_LAST) begin
				opt_next = csc_pkg::csc_opt_s'(opt_sync);
				opt_valid_next = 1'b1;
			end else begin
				settle_next = settle_reg + 3'h1;
			end
		end else if (poc_hold_reg) begin
			if (!opt_reg.poc_mode || (poc_cnt_reg == POC_LAST)) begin
				poc_hold_next = 1'b0; // [RQ17]
			end else begin
				poc_cnt_next = poc_cnt_reg + `CSC_POC_CNT_W'(1); // [RQ17]
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			settle_reg <= 3'h0;
			opt_valid_reg <= 1'b0;
			opt_reg <= '0;
			poc_cnt_reg <= '0;
			poc_hold_reg <= 1'b1;
		end else begin
			settle_reg <= settle_next;
			opt_valid_reg <= opt_valid_next;
			opt_reg <= opt_next;
			poc_cnt_reg <= poc_cnt_next;
			poc_hold_reg <= poc_hold_next;
		end
	end

	// Oscillator enables; STOP halts only the internal high-speed oscillator
	assign ls_run = !ls_stop_reg || opt_reg.lowspd_nostop; // [RQ7] [RQ8]
	always_comb begin
		osc_next.ihs_run = !ihs_stop_reg && !STOP_MODE;
		osc_next.main_xtal = main_sel_reg && !main_ext_reg && !main_osc_stop_reg; // [RQ9]
		osc_next.main_ext = main_sel_reg && main_ext_reg && !main_osc_stop_reg; // [RQ9]
		osc_next.main_freq_range = range_reg;
		// Start bit forces the crystal regardless of the select pair
		osc_next.sub_xtal = xstart_reg || (sub_sel_reg && !sub_ext_reg); // [RQ2] [RQ4]
		osc_next.sub_ext = !xstart_reg && sub_sel_reg && sub_ext_reg; // [RQ2] [RQ4]
		osc_next.lowspd_run = ls_run; // [RQ6]
		osc_next.wdt_clk = ls_run && opt_reg.wdt_en; // [RQ5] [RQ6]
		cdiv_next = (cpu_cur == csc_pkg::CSC_SRC_SUB) ? `CSC_DIV_SUB : div_reg; // [RQ18] [RQ19]
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			osc_reg <= '0;
			cdiv_reg <= `CSC_RST_DIV;
		end else begin
			osc_reg <= osc_next;
			cdiv_reg <= cdiv_next;
		end
	end

	// Port drive; gates stay shut until the straps are known and the hold ends
	assign PRDATA = rdata_reg;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign CPU_SRC = cpu_cur; // [RQ13]
	assign CPU_CLK_GATE = cpu_gate && !poc_hold_reg; // [RQ17] [RQ20]
	assign CPU_DIV_EXP = cdiv_reg;
	assign PERI_SRC = peri_cur;
	assign PERI_CLK_GATE = peri_gate && !poc_hold_reg;
	assign OSC_EN = osc_reg;
endmodule

// file: verif/csc_top_props.sv
// Concurrent checks on the clock source control, seen from the top-level ports only.
// Assumes straps are static across each reset and MCLK is the only clock.
`timescale 1ns/1ps
module csc_top_props (
	input wire logic MCLK, // System clock
	input wire logic RST_B, // Reset, active low
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB enable
	input wire logic PWRITE, // APB write
	input csc_pkg::csc_opt_s OPT_PINS, // Option straps
	input wire logic STOP_MODE, // STOP standby
	input csc_pkg::csc_src_e CPU_SRC, // CPU source
	input wire logic CPU_CLK_GATE, // CPU gate open
	input wire logic [2:0] CPU_DIV_EXP, // CPU divide exponent
	input csc_pkg::csc_src_e PERI_SRC, // Peripheral source
	input csc_pkg::csc_osc_en_s OSC_EN // Oscillator enables
);
	logic [11:0] run_cnt_reg;
	logic [11:0] run_cnt_next;
	// Cycles since reset release; saturates so a long run never wraps back into the hold window
	always_comb begin
		run_cnt_next = (run_cnt_reg == 12'hFFF) ? run_cnt_reg : run_cnt_reg + 12'h001;
	end
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			run_cnt_reg <= 12'h000;
		end else begin
			run_cnt_reg <= run_cnt_next;
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	// Source codes, reset state and watchdog feed
	a_no_lowspd_cpu: assert property (CPU_SRC != 2'h3) else $error("CPU source code out of range");
	a_peri_no_sub: assert property (PERI_SRC != csc_pkg::CSC_SRC_SUB) else $error("Peripherals on subsystem clock");
	a_boot_on_ihs: assert property (run_cnt_reg < 12'h004 |-> CPU_SRC == csc_pkg::CSC_SRC_IHS && PERI_SRC == csc_pkg::CSC_SRC_IHS)
		else $error("Not on internal clock after reset");
	a_lowspd_starts: assert property (run_cnt_reg == 12'h001 |-> OSC_EN.lowspd_run && OSC_EN.ihs_run)
		else $error("Oscillators not started after reset");
	a_wdt_from_lowspd: assert property (OSC_EN.wdt_clk |-> OSC_EN.lowspd_run) else $error("Watchdog clock without low-speed osc");
	// Divider and handover
	a_sub_div_two: assert property (CPU_SRC == csc_pkg::CSC_SRC_SUB && $past(CPU_SRC) == csc_pkg::CSC_SRC_SUB |-> CPU_DIV_EXP == 3'h1)
		else $error("Subsystem CPU clock not halved");
	a_swap_gated: assert property ($changed(CPU_SRC) |-> !$past(CPU_CLK_GATE)) else $error("Source changed with gate open");
	// Standby, power-on hold and low-speed control; enables trail a write by two edges
	a_stop_keeps_sub: assert property (STOP_MODE && !(PSEL && PWRITE) && !$past(PSEL && PWRITE) |=>
		$stable(OSC_EN.sub_xtal) && $stable(OSC_EN.sub_ext)) else $error("STOP changed subsystem enables");
	a_poc_hold: assert property (OPT_PINS.poc_mode && run_cnt_reg < 12'h7D0 |-> !CPU_CLK_GATE) else $error("Gate open in POC hold");
	a_nostop_runs: assert property (OPT_PINS.lowspd_nostop && run_cnt_reg > 12'h010 |-> OSC_EN.lowspd_run)
		else $error("Non-stoppable low-speed osc stopped");
	a_lowspd_sw_stop: assert property ($fell(OSC_EN.lowspd_run) |-> $past(PSEL && PENABLE && PWRITE, 2))
		else $error("Low-speed osc stopped without a write");
endmodule

bind csc_top csc_top_props props_u (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.OPT_PINS(OPT_PINS), .STOP_MODE(STOP_MODE), .CPU_SRC(CPU_SRC), .CPU_CLK_GATE(CPU_CLK_GATE),
	.CPU_DIV_EXP(CPU_DIV_EXP), .PERI_SRC(PERI_SRC), .OSC_EN(OSC_EN));

// file: verif/csc_top_tb.sv
// Self-checking bench for the clock source control: APB register traffic and source switching.
// Assumes the design files and package are compiled first; clock levels are slow square waves.
`timescale 1ns/1ps
module csc_top_tb;
	logic MCLK = 1'b0;
	logic RST_B = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h00000000;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	csc_pkg::csc_opt_s OPT_PINS = 3'h4;
	logic STOP_MODE = 1'b0;
	logic [2:0] CLK_LVL = 3'h0;
	csc_pkg::csc_src_e CPU_SRC;
	logic CPU_CLK_GATE;
	logic [2:0] CPU_DIV_EXP;
	csc_pkg::csc_src_e PERI_SRC;
	logic PERI_CLK_GATE;
	csc_pkg::csc_osc_en_s OSC_EN;
	logic [5:0] lvl_cnt = 6'h00;
	logic [31:0] rd_data;
	logic rd_err;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;

	csc_top dut_u (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .OPT_PINS(OPT_PINS),
		.STOP_MODE(STOP_MODE), .CLK_LVL(CLK_LVL), .CPU_SRC(CPU_SRC), .CPU_CLK_GATE(CPU_CLK_GATE),
		.CPU_DIV_EXP(CPU_DIV_EXP), .PERI_SRC(PERI_SRC), .PERI_CLK_GATE(PERI_CLK_GATE), .OSC_EN(OSC_EN));

	initial begin
		forever #5 MCLK = ~MCLK;
	end

	// Oscillator levels at slow related rates (periods of 16, 32 and 64 cycles), so every source has long low phases
	always @(posedge MCLK) begin
		lvl_cnt <= lvl_cnt + 6'h01;
		CLK_LVL <= {lvl_cnt[5], lvl_cnt[4], lvl_cnt[3]};
	end

	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Hang guard: the whole sequence needs well under 6000 cycles
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; request held until PREADY is sampled high
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= addr;
		PWDATA <= data;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		@(posedge MCLK);
		while (PREADY !== 1'b1) @(posedge MCLK);
		rd_data = PRDATA;
		rd_err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	// Outputs follow a register one edge after the write lands
	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		apb(1'b1, addr, data);
		repeat (2) @(negedge MCLK);
	endtask

	task automatic chk_rd(input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h00000000);
		check(rd_data, exp);
	endtask

	// Bounded wait for a handover, then one more edge for the divider
	task automatic wait_src(input csc_pkg::csc_src_e s);
		int i;
		for (i = 0; i < 400 && CPU_SRC !== s; i++) @(negedge MCLK);
		@(negedge MCLK);
		check({30'h0, CPU_SRC}, {30'h0, s});
	endtask

	initial begin
		repeat (3) @(posedge MCLK);
		RST_B <= 1'b1;
		repeat (12) @(negedge MCLK);
		// Reset state
		check({24'h0, OSC_EN}, 32'h00000083);
		check({28'h0, CPU_SRC, CPU_CLK_GATE, PERI_CLK_GATE}, 32'h00000003);
		check({30'h0, PERI_SRC}, 32'h00000000);
		chk_rd(8'h00, 32'h00000001);
		chk_rd(8'h04, 32'h00000000);
		chk_rd(8'h0C, 32'h00000080);
		apb(1'b0, 8'h20, 32'h00000000);
		check({rd_data[30:0], rd_err}, 32'h00000001);
		// Low-speed stop and restart
		wr(8'h10, 32'h00000002);
		check({24'h0, OSC_EN}, 32'h00000080);
		wr(8'h10, 32'h00000000);
		check({24'h0, OSC_EN}, 32'h00000083);
		// Subsystem enables, STOP leaves them alone, clearing select stops them
		wr(8'h08, 32'h00000030);
		check({28'h0, OSC_EN[3:0]}, 32'h00000007);
		@(posedge MCLK);
		STOP_MODE <= 1'b1;
		repeat (4) @(negedge MCLK);
		check({24'h0, OSC_EN}, 32'h00000007);
		@(posedge MCLK);
		STOP_MODE <= 1'b0;
		wr(8'h08, 32'h00000010);
		check({28'h0, OSC_EN[3:0]}, 32'h0000000B);
		chk_rd(8'h00, 32'h00000001);
		wr(8'h08, 32'h00000000);
		check({28'h0, OSC_EN[3:0]}, 32'h00000003);
		// Main crystal, range bit locked after first change
		wr(8'h0C, 32'h00000000);
		wr(8'h08, 32'h00000071);
		check({25'h0, OSC_EN[6:0]}, 32'h00000057);
		wr(8'h08, 32'h00000070);
		chk_rd(8'h08, 32'h00000071);
		// Switch to high-speed system clock
		wr(8'h04, 32'h00000005);
		wait_src(csc_pkg::CSC_SRC_HS);
		check({30'h0, PERI_SRC}, {30'h0, csc_pkg::CSC_SRC_HS});
		chk_rd(8'h04, 32'h00000007);
		chk_rd(8'h00, 32'h00000001);
		wr(8'h04, 32'h00000001);
		chk_rd(8'h04, 32'h00000007);
		// Divider codes, a prohibited one is dropped
		wr(8'h00, 32'h00000003);
		check({29'h0, CPU_DIV_EXP}, 32'h00000003);
		wr(8'h00, 32'h00000005);
		chk_rd(8'h00, 32'h00000003);
		// Subsystem CPU clock and back
		wr(8'h00, 32'h00000013);
		wait_src(csc_pkg::CSC_SRC_SUB);
		check({29'h0, CPU_DIV_EXP}, 32'h00000001);
		chk_rd(8'h00, 32'h00000033);
		check({30'h0, PERI_SRC}, {30'h0, csc_pkg::CSC_SRC_HS});
		wr(8'h00, 32'h00000003);
		wait_src(csc_pkg::CSC_SRC_HS);
		check({29'h0, CPU_DIV_EXP}, 32'h00000003);
		// Second reset: watchdog off, low-speed non-stoppable, dual-threshold hold
		@(posedge MCLK);
		RST_B <= 1'b0;
		OPT_PINS <= 3'h3;
		repeat (3) @(posedge MCLK);
		RST_B <= 1'b1;
		repeat (1500) @(negedge MCLK);
		check({30'h0, CPU_CLK_GATE, PERI_CLK_GATE}, 32'h00000000);
		repeat (800) @(negedge MCLK);
		check({31'h0, CPU_CLK_GATE}, 32'h00000001);
		wr(8'h10, 32'h00000002);
		check({30'h0, OSC_EN[1:0]}, 32'h00000002);
		wr(8'h08, 32'h00000001);
		chk_rd(8'h08, 32'h00000001);
		end_of_test();
	end
endmodule
